/* common/vtpg_pkg.sv */
// Shared constants and carriers for the video test pattern generator
package vtpg_pkg;
  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_MON  = 8'h63;
  localparam logic [7:0] IDX_CTL  = 8'h64;
  localparam logic [7:0] IDX_CFG  = 8'h65;
  localparam logic [7:0] IDX_HTIM = 8'h70;
  localparam logic [7:0] IDX_VTIM = 8'h71;
  localparam logic [7:0] IDX_SYNC = 8'h72;
  localparam logic [7:0] IDX_SCRL = 8'h73;
  localparam logic [7:0] IDX_CUST = 8'h74;
  localparam logic [7:0] IDX_STAT = 8'h75;
  localparam logic [7:0] IDX_NONE = 8'hff;
  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CTL_EN     = 0;
  localparam int CTL_VREV   = 1;
  localparam int CTL_BARS   = 2;
  localparam int CTL_COMPLY = 3;
  localparam int CTL_SEL    = 4;
  localparam int CFG_SCRL   = 0;
  localparam int CFG_INV    = 1;
  localparam int CFG_TSEL   = 2;
  localparam int CFG_EXTCLK = 3;
  localparam int CFG_18B    = 4;
  localparam int SCRL_HPOL  = 8;
  localparam int SCRL_VPOL  = 9;
  localparam int SCRL_CVP   = 10;
  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  CTL_RST  = 8'h10;
  localparam logic [4:0]  CFG_RST  = 5'h00;
  localparam logic [31:0] HTIM_RST = 32'h0280_0320;
  localparam logic [31:0] VTIM_RST = 32'h01e0_020d;
  localparam logic [31:0] SYNC_RST = 32'h2102_3060;
  localparam logic [31:0] SCRL_RST = 32'h0000_003c;
  localparam logic [23:0] CUST_RST = 24'h00_0000;
  // ----------------------------------------------------------------
  // Pattern codes
  // ----------------------------------------------------------------
  localparam logic [3:0] CODE_FIRST  = 4'h1;
  localparam logic [3:0] CODE_LAST   = 4'he;
  localparam logic [3:0] CODE_CUSTOM = 4'he;
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_FIXED, SRC_BARS, SRC_COMPLY, SRC_CVP
  } vtpg_src_t;
  typedef struct packed {
    logic        de;
    logic        hs;
    logic        vs;
    logic [23:0] rgb;
  } vtpg_video_t;
  typedef struct packed {
    logic        hpol;
    logic        vpol;
    logic [11:0] htot;
    logic [11:0] hact;
    logic [11:0] vtot;
    logic [11:0] vact;
    logic [7:0]  hsw;
    logic [7:0]  hbp;
    logic [7:0]  vsw;
    logic [7:0]  vbp;
  } vtpg_tcfg_t;
  typedef struct packed {
    logic        stb;
    logic        sof;
    logic        de;
    logic        hs;
    logic        vs;
    logic [11:0] x;
    logic [11:0] y;
  } vtpg_tim_t;
endpackage

/* rtl/vtpg_color.sv */
// Colour of one pixel for the chosen pattern
`timescale 1ns/100ps
module vtpg_color (
  // Pattern choice
  input  vtpg_pkg::vtpg_src_t src,
  input  logic [3:0]          code,
  input  logic                inv,
  input  logic                b18,
  input  logic                vrev,
  input  logic [23:0]         cust,
  // Position and span
  input  logic [11:0]         x,
  input  logic [11:0]         y,
  input  logic [11:0]         hact,
  input  logic [11:0]         vact,
  // Colour
  output logic [23:0]         rgb
);
  localparam logic [2:0] BAR_TBL [8] = '{3'h7, 3'h6, 3'h3, 3'h2,
                                         3'h5, 3'h4, 3'h1, 3'h0};
  localparam logic [2:0] CVP_TBL [4]  = '{3'h6, 3'h3, 3'h1, 3'h4};
  localparam logic [2:0] VREV_TBL [4] = '{3'h1, 3'h3, 3'h6, 3'h4};
  localparam logic [2:0] GRAD_TBL [4] = '{3'h7, 3'h4, 3'h2, 3'h1};

  logic [19:0] hq;
  logic [19:0] vq;
  logic [7:0]  lh;
  logic [7:0]  lv;
  logic [2:0]  m;
  logic [7:0]  l;
  logic [23:0] raw;

  assign hq = {x, 8'h00} / {8'h00, (hact == 12'h000) ? 12'h001 : hact};
  assign vq = {y, 8'h00} / {8'h00, (vact == 12'h000) ? 12'h001 : vact};
  assign lh = (hq > 20'h000ff) ? 8'hff : hq[7:0];
  assign lv = (vq > 20'h000ff) ? 8'hff : vq[7:0];

  always_comb begin
    m = 3'h0;
    l = 8'hff;
    case (src)
      vtpg_pkg::SRC_COMPLY: m = {3{x[0] ^ y[0]}};
      vtpg_pkg::SRC_BARS:   m = BAR_TBL[lh[7:5]];
      vtpg_pkg::SRC_CVP:    m = vrev ? VREV_TBL[lv[7:6]] : CVP_TBL[lv[7:6]];
      default: begin
        case (code)
          4'h1: m = 3'h7;
          4'h2: m = 3'h0;
          4'h3: m = 3'h4;
          4'h4: m = 3'h2;
          4'h5: m = 3'h1;
          4'h6, 4'h7, 4'h8, 4'h9: begin
            m = GRAD_TBL[code[1:0] + 2'h2];
            l = b18 ? {lh[7:2], 2'b00} : lh;
          end
          4'ha, 4'hb, 4'hc, 4'hd: begin
            m = GRAD_TBL[code[1:0] + 2'h2];
            l = b18 ? {lv[7:2], 2'b00} : lv;
          end
          default: m = 3'h0;
        endcase
      end
    endcase
    raw = {m[2] ? l : 8'h00, m[1] ? l : 8'h00, m[0] ? l : 8'h00};
    if (src == vtpg_pkg::SRC_FIXED && code == vtpg_pkg::CODE_CUSTOM) begin
      raw = cust;
    end
    if (inv) begin
      raw = ~raw;
    end
    rgb = raw & (b18 ? 24'hfcfcfc : 24'hffffff);
  end
endmodule

/* rtl/vtpg_timing.sv */
// Raster timing: internal counters or tracking of external sync
`timescale 1ns/100ps
module vtpg_timing (
  // Clock, reset, enable
  input  logic                 hclk,
  input  logic                 hresetn,
  input  logic                 ce,
  // Control
  input  logic                 run,
  input  logic                 tsel,
  input  logic                 pix_en,
  input  vtpg_pkg::vtpg_tcfg_t tcfg,
  input  vtpg_pkg::vtpg_video_t ext,
  // Raster position
  output vtpg_pkg::vtpg_tim_t  tim
);
  typedef struct packed {
    vtpg_pkg::vtpg_tim_t t;
    logic [11:0]         hcnt;
    logic [11:0]         vcnt;
    logic                pvs;
    logic                pde;
  } vtpg_tstate_t;

  vtpg_tstate_t s;
  vtpg_tstate_t n;
  logic [11:0]  hst;
  logic [11:0]  vst;
  logic         vsa;

  assign hst = {4'h0, tcfg.hsw} + {4'h0, tcfg.hbp};
  assign vst = {4'h0, tcfg.vsw} + {4'h0, tcfg.vbp};
  assign vsa = ext.vs ^ tcfg.vpol;
  assign tim = s.t;

  always_comb begin
    n = s;
    n.t.stb = 1'b0;
    n.t.sof = 1'b0;
    if (!run) begin
      n = '0;
    end else if (pix_en) begin
      n.t.stb = 1'b1;
      if (tsel) begin
        n.t.de = (s.hcnt >= hst) && (s.hcnt < hst + tcfg.hact) &&
                 (s.vcnt >= vst) && (s.vcnt < vst + tcfg.vact);
        n.t.hs = (s.hcnt < {4'h0, tcfg.hsw}) ^ tcfg.hpol;
        n.t.vs = (s.vcnt < {4'h0, tcfg.vsw}) ^ tcfg.vpol;
        n.t.x = s.hcnt - hst;
        n.t.y = s.vcnt - vst;
        n.t.sof = (s.hcnt == 12'h000) && (s.vcnt == 12'h000);
        n.hcnt = s.hcnt + 12'h001;
        if (s.hcnt >= tcfg.htot - 12'h001) begin
          n.hcnt = 12'h000;
          n.vcnt = (s.vcnt >= tcfg.vtot - 12'h001) ? 12'h000
                                                    : s.vcnt + 12'h001;
        end
      end else begin
        n.t.de = ext.de;
        n.t.hs = ext.hs;
        n.t.vs = ext.vs;
        n.t.x = (ext.de && s.pde) ? s.t.x + 12'h001 : 12'h000;
        if (vsa && !s.pvs) begin
          n.t.y = 12'h000;
        end else if (!ext.de && s.pde) begin
          n.t.y = s.t.y + 12'h001;
        end
        n.t.sof = vsa && !s.pvs;
        n.pvs = vsa;
        n.pde = ext.de;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s <= '0;
    end else if (ce) begin
      s <= n;
    end
  end
endmodule

/* rtl/vtpg_top.sv */
// Video test pattern generator with AHB-Lite register slave
`timescale 1ns/100ps
module vtpg_top #(
  parameter int PCLK_DIV = 2
) (
  // Clock, reset, enable
  input  logic                  hclk,
  input  logic                  hresetn,
  input  logic                  ce,
  // AHB-Lite slave
  input  logic                  hsel,
  input  logic [31:0]           haddr,
  input  logic [1:0]            htrans,
  input  logic                  hwrite,
  input  logic [2:0]            hsize,
  input  logic [31:0]           hwdata,
  input  logic                  hready,
  output logic                  hreadyout,
  output logic [31:0]           hrdata,
  output logic                  hresp,
  // Received video pins
  input  logic                  vin_pclk,
  input  vtpg_pkg::vtpg_video_t vin,
  // Video towards the display path
  output vtpg_pkg::vtpg_video_t vout,
  output logic                  vout_stb,
  // Monitor output driver
  output logic                  monitor_output_driver_pwdn
);
  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  if (PCLK_DIV < 1 || PCLK_DIV > 256) begin : g_bad_div
    $error("PCLK_DIV must be 1 to 256");
  end
  localparam logic [7:0] DIV_LAST = 8'(PCLK_DIV - 1);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic                  mon;
    logic [7:0]            ctl;
    logic [4:0]            cfg;
    logic [31:0]           htim;
    logic [31:0]           vtim;
    logic [31:0]           sync;
    logic [31:0]           scrl;
    logic [23:0]           cust;
    logic [31:0]           rdata;
    logic                  wpend;
    logic [7:0]            widx;
    vtpg_pkg::vtpg_video_t s1;
    vtpg_pkg::vtpg_video_t s2;
    logic                  p1;
    logic                  p2;
    logic                  p3;
    logic [7:0]            div;
    logic [7:0]            fcnt;
    logic [3:0]            cur;
    vtpg_pkg::vtpg_src_t   src;
    vtpg_pkg::vtpg_video_t vo;
    logic                  vstb;
  } vtpg_state_t;

  vtpg_state_t          s;
  vtpg_state_t          n;
  vtpg_pkg::vtpg_tcfg_t tcfg;
  vtpg_pkg::vtpg_tim_t  tim;
  vtpg_pkg::vtpg_src_t  pick;
  logic [23:0]          col;
  logic [7:0]           aidx;
  logic [3:0]           sel;
  logic [3:0]           nxt;
  logic                 run;
  logic                 ascrl;
  logic                 tsel;
  logic                 pix_en;
  logic                 ext_rise;
  logic                 last_frame;

  assign run   = s.ctl[vtpg_pkg::CTL_EN];
  assign sel   = s.ctl[vtpg_pkg::CTL_SEL +: 4];
  assign ascrl = s.cfg[vtpg_pkg::CFG_SCRL];
  assign tsel  = s.cfg[vtpg_pkg::CFG_TSEL];

  assign tcfg.hpol = s.scrl[vtpg_pkg::SCRL_HPOL];
  assign tcfg.vpol = s.scrl[vtpg_pkg::SCRL_VPOL];
  assign tcfg.htot = s.htim[11:0];
  assign tcfg.hact = s.htim[27:16];
  assign tcfg.vtot = s.vtim[11:0];
  assign tcfg.vact = s.vtim[27:16];
  assign tcfg.hsw  = s.sync[7:0];
  assign tcfg.hbp  = s.sync[15:8];
  assign tcfg.vsw  = s.sync[23:16];
  assign tcfg.vbp  = s.sync[31:24];

  // ----------------------------------------------------------------
  // Pixel clock choice
  // ----------------------------------------------------------------
  // Edge taken from the second sync stage, never the first
  assign ext_rise = s.p2 & ~s.p3;
  // clock source only under internal timing
  assign pix_en = (tsel && !s.cfg[vtpg_pkg::CFG_EXTCLK]) ?
                  (s.div == 8'h00) : ext_rise;

  // ----------------------------------------------------------------
  // Pattern source and scroll order
  // ----------------------------------------------------------------
  // compliance wins over everything else
  assign pick = s.ctl[vtpg_pkg::CTL_COMPLY] ? vtpg_pkg::SRC_COMPLY :
                s.ctl[vtpg_pkg::CTL_BARS]   ? vtpg_pkg::SRC_BARS :
                s.scrl[vtpg_pkg::SCRL_CVP]  ? vtpg_pkg::SRC_CVP :
                                              vtpg_pkg::SRC_FIXED;
  // Reserved codes are skipped while scrolling
  assign nxt = (s.cur >= vtpg_pkg::CODE_LAST) ? vtpg_pkg::CODE_FIRST
                                              : s.cur + 4'h1;
  assign last_frame = ({1'b0, s.fcnt} + 9'h001) >= {1'b0, s.scrl[7:0]};

  // Upper address bits must be clear, else unmapped
  assign aidx = (haddr[31:10] == 22'h0) ? haddr[9:2] : vtpg_pkg::IDX_NONE;

  function automatic logic [31:0] rd_word(input vtpg_state_t st,
                                          input logic [7:0]  idx,
                                          input logic [31:0] stat);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (idx)
      vtpg_pkg::IDX_MON:  w = {31'h0, st.mon};
      vtpg_pkg::IDX_CTL:  w = {24'h0, st.ctl};
      vtpg_pkg::IDX_CFG:  w = {27'h0, st.cfg};
      vtpg_pkg::IDX_HTIM: w = st.htim;
      vtpg_pkg::IDX_VTIM: w = st.vtim;
      vtpg_pkg::IDX_SYNC: w = st.sync;
      vtpg_pkg::IDX_SCRL: w = st.scrl;
      vtpg_pkg::IDX_CUST: w = {8'h00, st.cust};
      vtpg_pkg::IDX_STAT: w = stat;
      default:            w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = s;
    // Two-stage synchronisers for pins
    n.s1 = vin;
    n.s2 = s.s1;
    n.p1 = vin_pclk;
    n.p2 = s.p1;
    n.p3 = s.p2;
    n.div = (s.div >= DIV_LAST) ? 8'h00 : s.div + 8'h01;

    // Write lands in the data phase
    n.wpend = 1'b0;
    if (s.wpend) begin
      case (s.widx)
        vtpg_pkg::IDX_MON:  n.mon  = hwdata[0];
        vtpg_pkg::IDX_CTL:  n.ctl  = hwdata[7:0];
        vtpg_pkg::IDX_CFG:  n.cfg  = hwdata[4:0];
        vtpg_pkg::IDX_HTIM: n.htim = hwdata;
        vtpg_pkg::IDX_VTIM: n.vtim = hwdata;
        vtpg_pkg::IDX_SYNC: n.sync = hwdata;
        vtpg_pkg::IDX_SCRL: n.scrl = hwdata;
        vtpg_pkg::IDX_CUST: n.cust = hwdata[23:0];
        default: ;
      endcase
    end
    if (hsel && htrans[1] && hready) begin
      n.wpend = hwrite;
      n.widx  = aidx;
      // Read sees a write landing in its own address phase
      if (!hwrite) begin
        n.rdata = rd_word(n, aidx,
                          {15'h0, run, s.fcnt, 2'b00, s.src, s.cur});
      end
    end

    // idle: counter clear, selection tracks register
    if (!run) begin
      n.fcnt = 8'h00;
      n.cur  = sel;
      n.src  = pick;
    end else if (tim.sof) begin
      n.src = pick;
      if (ascrl) begin
        if (last_frame) begin
          n.fcnt = 8'h00;
          n.cur  = nxt;
        end else begin
          n.fcnt = s.fcnt + 8'h01;
        end
      end else begin
        n.fcnt = 8'h00;
        n.cur  = sel;
      end
    end

    n.vstb = run ? tim.stb : pix_en;
    if (run && tim.stb) begin
      n.vo.de  = tim.de;
      n.vo.hs  = tim.hs;
      n.vo.vs  = tim.vs;
      n.vo.rgb = tim.de ? col : 24'h00_0000;
    end else if (!run && pix_en) begin
      n.vo = s.s2;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s      <= '0;
      s.ctl  <= vtpg_pkg::CTL_RST;
      s.cfg  <= vtpg_pkg::CFG_RST;
      s.htim <= vtpg_pkg::HTIM_RST;
      s.vtim <= vtpg_pkg::VTIM_RST;
      s.sync <= vtpg_pkg::SYNC_RST;
      s.scrl <= vtpg_pkg::SCRL_RST;
      s.cust <= vtpg_pkg::CUST_RST;
      s.cur  <= vtpg_pkg::CODE_FIRST;
      s.src  <= vtpg_pkg::SRC_FIXED;
    end else if (ce) begin
      s <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s.rdata;
  assign vout      = s.vo;
  assign vout_stb  = s.vstb;
  assign monitor_output_driver_pwdn = s.mon;

  // ----------------------------------------------------------------
  // Children
  // ----------------------------------------------------------------
  vtpg_timing u_timing (
    .hclk    (hclk),
    .hresetn (hresetn),
    .ce      (ce),
    .run     (run),
    .tsel    (tsel),
    .pix_en  (pix_en),
    .tcfg    (tcfg),
    .ext     (s.s2),
    .tim     (tim)
  );

  vtpg_color u_color (
    .src  (s.src),
    .code (s.cur),
    .inv  (s.cfg[vtpg_pkg::CFG_INV]),
    .b18  (s.cfg[vtpg_pkg::CFG_18B]),
    .vrev (s.ctl[vtpg_pkg::CTL_VREV]),
    .cust (s.cust),
    .x    (tim.x),
    .y    (tim.y),
    .hact (tcfg.hact),
    .vact (tcfg.vact),
    .rgb  (col)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_pass_through: assert property (
    ce && !run && pix_en |=> vout.rgb == $past(s.s2.rgb) && vout_stb)
    else $error("disabled video not passed through");

  a_cnt_cleared: assert property (
    ce && !run |=> s.fcnt == 8'h00)
    else $error("frame counter not clear while disabled");

  a_sof_only: assert property (
    ce && run && !tim.sof ##1 run |-> $stable(s.cur))
    else $error("pattern changed away from frame start");

  a_scroll_adv: assert property (
    ce && run && ascrl && tim.sof && last_frame |=>
      s.cur == (($past(s.cur) >= 4'he) ? 4'h1 : $past(s.cur) + 4'h1)
      && s.fcnt == 8'h00)
    else $error("scroll did not advance after dwell");

  a_fixed_hold: assert property (
    ce && run && !ascrl && tim.sof |=> s.cur == $past(sel))
    else $error("fixed mode lost the selected pattern");

  a_comply_src: assert property (
    ce && run && s.ctl[vtpg_pkg::CTL_COMPLY] && tim.sof |=>
      s.src == vtpg_pkg::SRC_COMPLY)
    else $error("compliance pattern not chosen");

  a_bars_white: assert property (
    ce && run && s.src == vtpg_pkg::SRC_BARS && tim.stb && tim.de &&
    tim.x == 12'h000 && !s.cfg[vtpg_pkg::CFG_INV] &&
    !s.cfg[vtpg_pkg::CFG_18B] |=> vout.rgb == 24'hffffff)
    else $error("first colour bar is not white");

  a_depth_18: assert property (
    ce && run && tim.stb && s.cfg[vtpg_pkg::CFG_18B] |=>
      (vout.rgb & 24'h030303) == 24'h00_0000)
    else $error("low colour bits driven in 18-bit mode");

  a_ext_timing: assert property (
    ce && run && !tsel && pix_en |=> tim.de == $past(s.s2.de))
    else $error("external data enable not followed");

  a_blank_black: assert property (
    ce && run && tim.stb && !tim.de |=> vout.rgb == 24'h00_0000)
    else $error("colour outside the active region");

  c_scroll: cover property (ce && run && ascrl && tim.sof && last_frame);
  c_bars:   cover property (run && s.src == vtpg_pkg::SRC_BARS && tim.de);
  c_comply: cover property (run && s.src == vtpg_pkg::SRC_COMPLY);
  c_pass:   cover property (!run && pix_en && s.s2.de);
endmodule

/* sim/testbench.sv */
// Self-checking bench for the video test pattern generator
`timescale 1ns/100ps
module testbench;
  logic hclk, hresetn, hsel, hwrite, vin_pclk, hreadyout, hresp, stb, pwdn;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [23:0] last_rgb, frame_rgb, first_rgb;
  logic [15:0] frames;
  wire logic hready = hreadyout;
  vtpg_pkg::vtpg_video_t vin, vout;
  int bad_count, n_tests;
  // reserved codes avoided
  // Last active pixel is x=11, y=7 of a 12x8 active area
  logic [39:0] tab [17] = '{
    40'h11_04_ffffff,
    40'h11_06_000000,
    40'h21_04_000000,
    40'h31_06_00ffff,
    40'h41_04_00ff00,
    40'h51_06_ffff00,
    40'h61_04_eaeaea,
    40'h61_14_e8e8e8,
    40'h71_06_15ffff,
    40'hb1_04_e00000,
    40'he1_14_103454,
    40'he1_06_edcba9,
    40'h15_04_000000,
    40'h19_04_000000,
    40'h81_04_00ea00,
    40'hd1_04_0000e0,
    40'h61_0c_eaeaea
  };

  vtpg_top #(.PCLK_DIV(2)) vtpg_top_i (.hclk(hclk), .hresetn(hresetn),
    .ce(1'b1), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .vin_pclk(vin_pclk), .vin(vin), .vout(vout), .vout_stb(stb),
    .monitor_output_driver_pwdn(pwdn));
  vtpg_sink vtpg_sink_i (.hclk(hclk), .hresetn(hresetn), .vout(vout),
    .vout_stb(stb), .last_rgb(last_rgb), .frame_rgb(frame_rgb),
    .first_rgb(first_rgb), .frames(frames));

  // ------------------------------------------------------------
  // Bus and check tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic xfer(input logic w, input logic [7:0] i,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {22'h0, i, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rv = hrdata;
  endtask
  task automatic wait_frames(input int n);
    int f0;
    f0 = frames;
    for (int k = 0; k < 4000 && frames < f0 + n; k++) @(posedge hclk);
    if (frames < f0 + n) begin
      bad_count++;
      $display("[ERR] frames exp %0d got %0d", f0 + n, frames);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    xfer(0, vtpg_pkg::IDX_CTL, 0); chk("ctl", 32'h10, rv);
    xfer(0, vtpg_pkg::IDX_CFG, 0); chk("cfg", 32'h0, rv);
    xfer(1, vtpg_pkg::IDX_CFG, 32'hff);
    xfer(0, vtpg_pkg::IDX_CFG, 0); chk("cfg_rsv", 32'h1f, rv);
    xfer(1, vtpg_pkg::IDX_NONE, 32'h5a);
    xfer(0, vtpg_pkg::IDX_NONE, 0); chk("unmapped", 32'h0, rv);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic t_patterns;
    // Driver powered down before enabling
    xfer(1, vtpg_pkg::IDX_MON, 32'h1);
    xfer(1, vtpg_pkg::IDX_HTIM, 32'h000c_0018);
    chk("pwdn", 32'h1, {31'h0, pwdn});
    xfer(1, vtpg_pkg::IDX_VTIM, 32'h0008_000c);
    xfer(1, vtpg_pkg::IDX_SYNC, 32'h0101_0202);
    xfer(1, vtpg_pkg::IDX_CUST, 32'h0012_3456);
    foreach (tab[n]) begin
      xfer(1, vtpg_pkg::IDX_CTL, {24'h0, tab[n][39:32]});
      xfer(1, vtpg_pkg::IDX_CFG, {24'h0, tab[n][31:24]});
      wait_frames(2);
      chk($sformatf("pat%0d", n), tab[n][23:0], frame_rgb);
    end
  endtask
  task automatic t_scroll;
    xfer(1, vtpg_pkg::IDX_CTL, 32'hd0);
    xfer(1, vtpg_pkg::IDX_CFG, 32'h05);
    xfer(1, vtpg_pkg::IDX_SCRL, 32'h01);
    xfer(1, vtpg_pkg::IDX_CTL, 32'hd1);
    wait_frames(2);
    chk("scroll0", 32'h123456, frame_rgb);
    wait_frames(1);
    chk("scroll1", 32'hffffff, frame_rgb);
    xfer(0, vtpg_pkg::IDX_STAT, 0);
    chk("stat", 32'h0001_0002, rv);
  endtask
  task automatic t_cvp;
    xfer(1, vtpg_pkg::IDX_CFG, 32'h04);
    xfer(1, vtpg_pkg::IDX_SCRL, 32'h400);
    wait_frames(3);
    chk("cvp_top", 32'hffff00, first_rgb);
    chk("cvp_bottom", 32'hff0000, frame_rgb);
    xfer(1, vtpg_pkg::IDX_CTL, 32'hd3);
    wait_frames(3);
    chk("cvp_rev", 32'h0000ff, first_rgb);
  endtask
  task automatic t_ext;
    xfer(1, vtpg_pkg::IDX_SCRL, 32'h3c);
    xfer(1, vtpg_pkg::IDX_CTL, 32'h41);
    vin <= {3'b101, 24'ha5c33c};
    xfer(1, vtpg_pkg::IDX_CFG, 32'h08);
    repeat (40) @(posedge hclk);
    chk("ext_timing", 32'h00ff00, last_rgb);
  endtask
  task automatic t_pass;
    xfer(1, vtpg_pkg::IDX_CTL, 32'h10);
    vin <= {3'b100, 24'ha5c33c};
    repeat (40) @(posedge hclk);
    chk("passthru", 32'ha5c33c, last_rgb);
  endtask

  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  initial begin
    vin_pclk = 1'b0;
    forever begin
      repeat (2) @(posedge hclk);
      vin_pclk <= ~vin_pclk;
    end
  end
  initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    tally_and_finish();
  end
  initial begin
    {hresetn, hsel, hwrite, haddr, hwdata, htrans} = '0;
    vin = '0;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_patterns();
    t_scroll();
    t_cvp();
    t_ext();
    t_pass();
    tally_and_finish();
  end
endmodule

/* sim/vtpg_sink.sv */
// Display-side sink recording pixels and frame ends
`timescale 1ns/100ps
module vtpg_sink (
  // Clock and reset
  input logic                  hclk,
  input logic                  hresetn,
  // Video from the generator
  input vtpg_pkg::vtpg_video_t vout,
  input logic                  vout_stb,
  // Observations
  output logic [23:0]          last_rgb,
  output logic [23:0]          frame_rgb,
  output logic [23:0]          first_rgb,
  output logic [15:0]          frames
);
  logic        vs_q;
  logic        fresh;
  // Only strobed pixels count; vout holds between strobes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {last_rgb, frame_rgb, first_rgb, frames, vs_q, fresh} <= '0;
    end else if (vout_stb) begin
      vs_q <= vout.vs;
      if (vout.de) begin
        last_rgb <= vout.rgb;
      end
      // First active pixel of each frame
      if (vout.de && fresh) begin
        first_rgb <= vout.rgb;
      end
      if (vout.vs && !vs_q) begin
        frame_rgb <= last_rgb;
        frames    <= frames + 16'h1;
        fresh     <= 1'b1;
      end else if (vout.de) begin
        fresh     <= 1'b0;
      end
    end
  end
endmodule
